// ==== design/pfm_config_bank.sv ====
// per-frame modulation configuration register bank with illumination gating
module pfm_config_bank (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// register port behind the serial control interface
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_wr,
	input  wire logic [7:0]            reg_wdata,
	output logic [7:0]                 reg_rdata,
	output logic                       reg_hit,
	// sequencer side
	input  wire logic                  seq_start,
	input  wire logic [1:0]            frame_idx,
	input  wire logic                  gray_mode,
	input  wire logic                  dual_mode,
	input  wire logic                  integrating,
	input  wire logic                  mod_in,
	// decoded settings and illumination
	output pfm_pkg::pfm_frame_cfg_t    frame_cfg,
	output logic                       clip_negative,
	output logic                       illumination_output
);
	// live registers, index 1..3 are frames two to four
	logic [7:0] sample_q [1:3];
	logic [7:0] sample_d [1:3];
	logic [7:0] illum_q  [1:3];
	logic [7:0] illum_d  [1:3];
	logic [7:0] gmode_q, gmode_d, gillum_q, gillum_d;
	// snapshots taken at sequence start
	logic [7:0] snap_s_q [0:3];
	logic [7:0] snap_s_d [0:3];
	logic [7:0] snap_i_q [0:3];
	logic [7:0] snap_i_d [0:3];
	logic [7:0] snap_gm_q, snap_gm_d, snap_gi_q, snap_gi_d;
	logic [7:0] rdata_d;
	logic       hit_d;
	pfm_pkg::pfm_frame_cfg_t cfg_d;
	logic       clip_d, illum_out_d;
	logic [7:0] cur_s, cur_i;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction : merge

	// writes touch writable bits only; reserved bits keep reset values
	always_comb begin
		sample_d[1] = sample_q[1];
		sample_d[2] = sample_q[2];
		sample_d[3] = sample_q[3];
		illum_d[1]  = illum_q[1];
		illum_d[2]  = illum_q[2];
		illum_d[3]  = illum_q[3];
		gmode_d     = gmode_q;
		gillum_d    = gillum_q;
		if (reg_wr) begin
			case (reg_addr)
				pfm_pkg::ADDR_F2_SAMPLE: begin
					sample_d[1] = merge(sample_q[1], reg_wdata, pfm_pkg::MASK_SAMPLE);
				end
				pfm_pkg::ADDR_F3_SAMPLE: begin
					sample_d[2] = merge(sample_q[2], reg_wdata, pfm_pkg::MASK_SAMPLE);
				end
				pfm_pkg::ADDR_F4_SAMPLE: begin
					sample_d[3] = merge(sample_q[3], reg_wdata, pfm_pkg::MASK_SAMPLE);
				end
				pfm_pkg::ADDR_F2_ILLUM: begin
					illum_d[1] = merge(illum_q[1], reg_wdata, pfm_pkg::MASK_ILLUM);
				end
				pfm_pkg::ADDR_F3_ILLUM: begin
					illum_d[2] = merge(illum_q[2], reg_wdata, pfm_pkg::MASK_ILLUM);
				end
				pfm_pkg::ADDR_F4_ILLUM: begin
					illum_d[3] = merge(illum_q[3], reg_wdata, pfm_pkg::MASK_ILLUM);
				end
				pfm_pkg::ADDR_GRAY_MODE: begin
					gmode_d = merge(gmode_q, reg_wdata, pfm_pkg::MASK_GRAY_MODE);
				end
				pfm_pkg::ADDR_GRAY_ILLUM: begin
					gillum_d = merge(gillum_q, reg_wdata, pfm_pkg::MASK_ILLUM);
				end
				default: begin
				end
			endcase
		end
	end

	// readback; unmapped addresses read zero and drop reg_hit
	always_comb begin
		hit_d   = 1'b1;
		rdata_d = 8'h00;
		case (reg_addr)
			pfm_pkg::ADDR_F2_SAMPLE:  rdata_d = sample_q[1];
			pfm_pkg::ADDR_F3_SAMPLE:  rdata_d = sample_q[2];
			pfm_pkg::ADDR_F4_SAMPLE:  rdata_d = sample_q[3];
			pfm_pkg::ADDR_F2_ILLUM:   rdata_d = illum_q[1];
			pfm_pkg::ADDR_F3_ILLUM:   rdata_d = illum_q[2];
			pfm_pkg::ADDR_F4_ILLUM:   rdata_d = illum_q[3];
			pfm_pkg::ADDR_GRAY_MODE:  rdata_d = gmode_q;
			pfm_pkg::ADDR_GRAY_ILLUM: rdata_d = gillum_q;
			default:                  hit_d = 1'b0;
		endcase
	end

	// a sequence already running keeps its copy, so mid-sequence writes cannot tear it
	always_comb begin
		snap_gm_d = seq_start ? gmode_q : snap_gm_q;
		snap_gi_d = seq_start ? gillum_q : snap_gi_q;
		snap_s_d[0] = pfm_pkg::RST_F1_SAMPLE;
		snap_i_d[0] = pfm_pkg::RST_ILLUM;
	end

	genvar g;
	generate
		for (g = 1; g < pfm_pkg::NUM_FRAMES; g++) begin : g_snap
			always_comb begin
				snap_s_d[g] = seq_start ? sample_q[g] : snap_s_q[g];
				snap_i_d[g] = seq_start ? illum_q[g] : snap_i_q[g];
			end
		end
	endgenerate

	// decode of the active frame
	always_comb begin
		cur_s = gray_mode ? snap_gm_q : snap_s_q[frame_idx];
		cur_i = gray_mode ? snap_gi_q : snap_i_q[frame_idx];
		cfg_d.primary_sample   = cur_s[pfm_pkg::PRI_LSB +: 2];
		cfg_d.secondary_sample = dual_mode ? cur_s[pfm_pkg::SEC_LSB +: 2] : 2'h0;
		cfg_d.suppress_en      = cur_s[pfm_pkg::SUP_LSB +: 2] == pfm_pkg::SUP_ON;
		cfg_d.steady_on        = cur_i[pfm_pkg::STEADY_BIT];
		cfg_d.blank            = cur_i[pfm_pkg::BLANK_BIT];
		if (gray_mode) begin
			cfg_d.primary_sample   = 2'h0;
			cfg_d.secondary_sample = 2'h0;
			cfg_d.suppress_en      = 1'b0;
		end
		clip_d = gray_mode &&
			snap_gm_q[pfm_pkg::GMODE_LSB +: 2] == pfm_pkg::GMODE_SINGLE;
		// blanking outranks steady-on; outside integration the output stays low
		if (!integrating || cfg_d.blank) begin
			illum_out_d = 1'b0;
		end else if (cfg_d.steady_on) begin
			illum_out_d = 1'b1;
		end else begin
			illum_out_d = mod_in;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sample_q[1] <= pfm_pkg::RST_F2_SAMPLE;
			sample_q[2] <= pfm_pkg::RST_F3_SAMPLE;
			sample_q[3] <= pfm_pkg::RST_F4_SAMPLE;
			for (int i = 1; i < pfm_pkg::NUM_FRAMES; i++) begin
				illum_q[i] <= pfm_pkg::RST_ILLUM;
			end
			gmode_q  <= pfm_pkg::RST_GRAY_MODE;
			gillum_q <= pfm_pkg::RST_GRAY_ILLUM;
			snap_s_q[0] <= pfm_pkg::RST_F1_SAMPLE;
			snap_i_q[0] <= pfm_pkg::RST_ILLUM;
			snap_s_q[1] <= pfm_pkg::RST_F2_SAMPLE;
			snap_s_q[2] <= pfm_pkg::RST_F3_SAMPLE;
			snap_s_q[3] <= pfm_pkg::RST_F4_SAMPLE;
			for (int i = 1; i < pfm_pkg::NUM_FRAMES; i++) begin
				snap_i_q[i] <= pfm_pkg::RST_ILLUM;
			end
			snap_gm_q <= pfm_pkg::RST_GRAY_MODE;
			snap_gi_q <= pfm_pkg::RST_GRAY_ILLUM;
			reg_rdata <= 8'h00;
			reg_hit   <= 1'b0;
			frame_cfg <= '0;
			clip_negative       <= 1'b0;
			illumination_output <= 1'b0;
		end else begin
			for (int i = 1; i < pfm_pkg::NUM_FRAMES; i++) begin
				sample_q[i] <= sample_d[i];
				illum_q[i]  <= illum_d[i];
			end
			gmode_q  <= gmode_d;
			gillum_q <= gillum_d;
			for (int i = 0; i < pfm_pkg::NUM_FRAMES; i++) begin
				snap_s_q[i] <= snap_s_d[i];
				snap_i_q[i] <= snap_i_d[i];
			end
			snap_gm_q <= snap_gm_d;
			snap_gi_q <= snap_gi_d;
			reg_rdata <= rdata_d;
			reg_hit   <= hit_d;
			frame_cfg <= cfg_d;
			clip_negative       <= clip_d;
			illumination_output <= illum_out_d;
		end
	end

	property p_blank_off;
		@(posedge clk) disable iff (!resetn)
		(integrating && cur_i[pfm_pkg::BLANK_BIT]) |=> !illumination_output;
	endproperty
	a_blank_off: assert property (p_blank_off) else $error("illumination not off while blanked");

	property p_steady_on;
		@(posedge clk) disable iff (!resetn)
		(integrating && !cur_i[pfm_pkg::BLANK_BIT] && cur_i[pfm_pkg::STEADY_BIT])
			|=> illumination_output;
	endproperty
	a_steady_on: assert property (p_steady_on) else $error("illumination not steady on");

	property p_modulated;
		@(posedge clk) disable iff (!resetn)
		(integrating && cur_i[5:4] == 2'h0) |=> illumination_output == $past(mod_in);
	endproperty
	a_modulated: assert property (p_modulated) else $error("illumination not following modulation");

	property p_reserved_illum;
		@(posedge clk) disable iff (!resetn)
		((illum_q[1] | illum_q[2] | illum_q[3]) & ~pfm_pkg::MASK_ILLUM) == 8'h00;
	endproperty
	a_reserved_illum: assert property (p_reserved_illum) else $error("reserved bit set");

	property p_gray_reserved;
		@(posedge clk) disable iff (!resetn)
		(gillum_q & ~pfm_pkg::MASK_ILLUM) == 8'h06;
	endproperty
	a_gray_reserved: assert property (p_gray_reserved) else $error("gray reserved changed");

	property p_write_reads_back;
		@(posedge clk) disable iff (!resetn)
		(reg_wr && reg_addr == pfm_pkg::ADDR_F3_SAMPLE) ##1 (reg_addr == pfm_pkg::ADDR_F3_SAMPLE)
			|=> reg_rdata == ($past(reg_wdata, 2) & pfm_pkg::MASK_SAMPLE);
	endproperty
	a_write_reads_back: assert property (p_write_reads_back) else $error("readback mismatch");

	property p_secondary_dual;
		@(posedge clk) disable iff (!resetn)
		!dual_mode |=> frame_cfg.secondary_sample == 2'h0;
	endproperty
	a_secondary_dual: assert property (p_secondary_dual) else $error("secondary set outside dual");

	property p_suppress;
		@(posedge clk) disable iff (!resetn)
		(!gray_mode && cur_s[5:4] != 2'h3) |=> !frame_cfg.suppress_en;
	endproperty
	a_suppress: assert property (p_suppress) else $error("suppression on for non-enable code");

	property p_primary;
		@(posedge clk) disable iff (!resetn)
		!gray_mode |=> frame_cfg.primary_sample == $past(cur_s[1:0]);
	endproperty
	a_primary: assert property (p_primary) else $error("primary sample mismatch");

	property p_clip;
		@(posedge clk) disable iff (!resetn)
		(gray_mode && snap_gm_q[5:4] == 2'h1) |=> clip_negative;
	endproperty
	a_clip: assert property (p_clip) else $error("single-ended readout not clipping");
endmodule : pfm_config_bank

// ==== design/pfm_pkg.sv ====
// package for the per-frame modulation configuration bank
// Summary of operation
// - steady bit set: illumination on, else modulated
// - blanking bit set: illumination held off
// - frame two sample select, reset 0x35
// - frame three sample select, reset 0x3A
// - frame four sample select, reset 0x3F
// - frames two-four modulation control, reset 0x00
// - single-ended grayscale readout clips negatives
// - grayscale illumination control register, reset 0x26
// - grayscale steady bit holds illumination on
// - grayscale blanking bit holds off, resets one
// - bits 1:0 pick primary modulator sample
// - bits 3:2 pick secondary sample, dual only
// - suppression field 11 on, 00 off
package pfm_pkg;
	localparam logic [7:0] ADDR_F2_SAMPLE = 8'h25;
	localparam logic [7:0] ADDR_F2_ILLUM  = 8'h26;
	localparam logic [7:0] ADDR_F3_SAMPLE = 8'h28;
	localparam logic [7:0] ADDR_F3_ILLUM  = 8'h29;
	localparam logic [7:0] ADDR_F4_SAMPLE = 8'h2B;
	localparam logic [7:0] ADDR_F4_ILLUM  = 8'h2D;
	localparam logic [7:0] ADDR_GRAY_MODE = 8'h34;
	localparam logic [7:0] ADDR_GRAY_ILLUM = 8'h3C;

	localparam logic [7:0] RST_F2_SAMPLE  = 8'h35;
	localparam logic [7:0] RST_F3_SAMPLE  = 8'h3A;
	localparam logic [7:0] RST_F4_SAMPLE  = 8'h3F;
	localparam logic [7:0] RST_ILLUM      = 8'h00;
	localparam logic [7:0] RST_GRAY_MODE  = 8'h10;
	localparam logic [7:0] RST_GRAY_ILLUM = 8'h26;
	// first-frame settings live elsewhere; their reset values stand in for frame one
	localparam logic [7:0] RST_F1_SAMPLE  = 8'h30;

	localparam logic [7:0] MASK_SAMPLE    = 8'h3F;
	localparam logic [7:0] MASK_ILLUM     = 8'h30;
	localparam logic [7:0] MASK_GRAY_MODE = 8'h30;

	localparam int PRI_LSB     = 0;
	localparam int SEC_LSB     = 2;
	localparam int SUP_LSB     = 4;
	localparam int STEADY_BIT  = 4;
	localparam int BLANK_BIT   = 5;
	localparam int GMODE_LSB   = 4;
	localparam logic [1:0] SUP_ON        = 2'h3;
	localparam logic [1:0] GMODE_SINGLE  = 2'h1;

	localparam int NUM_FRAMES = 4;

	typedef struct packed {
		logic [1:0] primary_sample;
		logic [1:0] secondary_sample;
		logic       suppress_en;
		logic       steady_on;
		logic       blank;
	} pfm_frame_cfg_t;
endpackage : pfm_pkg

// ==== testbench/pfm_host_model.sv ====
// host-side model of the serial control interface driving the register port
module pfm_host_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic [7:0]      reg_addr,
	output logic            reg_wr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_hit
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		reg_addr  = 8'hFF;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end
	// released data goes to its inverse so a stale byte never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr  <= a;
		reg_wr    <= 1'b1;
		reg_wdata <= d;
		@(negedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(negedge clk);
		reg_addr <= a;
		@(negedge clk);
		d = reg_rdata;
		h = reg_hit;
	endtask : rd
	// the host picks the grayscale readout itself
	task automatic set_gray_readout(input logic [1:0] m);
		wr(pfm_pkg::ADDR_GRAY_MODE, {2'h0, m, 4'h0});
	endtask : set_gray_readout
endmodule : pfm_host_model

// ==== testbench/per_frame_modulation_config_tb.sv ====
// self-checking bench for the per-frame modulation configuration bank
module per_frame_modulation_config_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                    clk, resetn, seq_start, gray_mode, dual_mode, integrating, mod_in;
	logic [1:0]              frame_idx;
	logic [7:0]              reg_addr, reg_wdata, reg_rdata, rv;
	logic                    reg_wr, reg_hit, clip_negative, illumination_output, rh;
	pfm_pkg::pfm_frame_cfg_t frame_cfg;
	int                      err_count, checks;
	logic [7:0] addrs [8] = '{pfm_pkg::ADDR_F2_SAMPLE, pfm_pkg::ADDR_F2_ILLUM,
		pfm_pkg::ADDR_F3_SAMPLE, pfm_pkg::ADDR_F3_ILLUM, pfm_pkg::ADDR_F4_SAMPLE,
		pfm_pkg::ADDR_F4_ILLUM, pfm_pkg::ADDR_GRAY_MODE, pfm_pkg::ADDR_GRAY_ILLUM};
	logic [7:0] rst_exp [8] = '{8'h35, 8'h00, 8'h3A, 8'h00, 8'h3F, 8'h00, 8'h10, 8'h26};
	logic [7:0] one_exp [8] = '{8'h3F, 8'h30, 8'h3F, 8'h30, 8'h3F, 8'h30, 8'h30, 8'h36};
	logic [7:0] nul_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06};

	pfm_config_bank dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.seq_start(seq_start), .frame_idx(frame_idx), .gray_mode(gray_mode),
		.dual_mode(dual_mode), .integrating(integrating), .mod_in(mod_in),
		.frame_cfg(frame_cfg), .clip_negative(clip_negative),
		.illumination_output(illumination_output));
	pfm_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// settings only reach the decode through the copy taken at sequence start
	task automatic start_seq;
		@(negedge clk);
		seq_start = 1'b1;
		@(negedge clk);
		seq_start = 1'b0;
	endtask : start_seq
	task automatic look(input logic [1:0] f, input logic m);
		@(negedge clk);
		frame_idx   = f;
		mod_in      = m;
		integrating = 1'b1;
		repeat (2) @(negedge clk);
	endtask : look
	task automatic fill(input logic [7:0] d, input int which);
		for (int i = 0; i < 8; i++)
			host.wr(addrs[i], d);
		for (int i = 0; i < 8; i++) begin
			host.rd(addrs[i], rv, rh);
			chk(which ? one_exp[i] : nul_exp[i], rv);
			chk(8'h01, {7'h0, rh});
		end
	endtask : fill

	initial begin
		#200us;
		err_count++;
		report_and_stop;
	end

	initial begin
		err_count = 0;
		checks = 0;
		{resetn, seq_start, gray_mode, integrating, mod_in} = '0;
		dual_mode = 1'b1;
		frame_idx = 2'h0;
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		for (int i = 0; i < 8; i++) begin
			host.rd(addrs[i], rv, rh);
			chk(rst_exp[i], rv);
			chk(8'h01, {7'h0, rh});
		end
		host.rd(8'h27, rv, rh);
		chk(8'h00, rv);
		chk(8'h00, {7'h0, rh});
		fill(8'hFF, 1);
		fill(8'h00, 0);
		host.wr(pfm_pkg::ADDR_F2_SAMPLE, 8'h36);
		host.wr(pfm_pkg::ADDR_F3_SAMPLE, 8'h1B);
		start_seq;
		look(2'h1, 1'b1);
		chk(8'h4C, {1'b0, frame_cfg});
		chk(8'h01, {7'h0, illumination_output});
		look(2'h2, 1'b0);
		chk(8'h70, {1'b0, frame_cfg});
		chk(8'h00, {7'h0, illumination_output});
		// single modulator: the secondary field must not reach the sequencer
		dual_mode = 1'b0;
		look(2'h1, 1'b1);
		chk(8'h44, {1'b0, frame_cfg});
		dual_mode = 1'b1;
		// steady written but not yet copied: frame still follows modulation
		host.wr(pfm_pkg::ADDR_F2_ILLUM, 8'h10);
		look(2'h1, 1'b0);
		chk(8'h00, {7'h0, illumination_output});
		start_seq;
		look(2'h1, 1'b0);
		chk(8'h01, {7'h0, illumination_output});
		host.wr(pfm_pkg::ADDR_F2_ILLUM, 8'h20);
		start_seq;
		look(2'h1, 1'b1);
		chk(8'h00, {7'h0, illumination_output});
		gray_mode = 1'b1;
		host.wr(pfm_pkg::ADDR_GRAY_ILLUM, 8'h20);
		host.set_gray_readout(2'h1);
		start_seq;
		look(2'h0, 1'b1);
		chk(8'h01, {7'h0, clip_negative});
		chk(8'h00, {7'h0, illumination_output});
		host.wr(pfm_pkg::ADDR_GRAY_ILLUM, 8'h10);
		host.set_gray_readout(2'h3);
		start_seq;
		look(2'h0, 1'b0);
		chk(8'h01, {7'h0, illumination_output});
		chk(8'h00, {7'h0, clip_negative});
		report_and_stop;
	end
endmodule : per_frame_modulation_config_tb
